// ### rtl/pwr_seq_map.svh
// Offsets, fields, reset values and timing counts of the power sequencer
// Assumes inclusion by bare name from rtl/
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH

// Register byte offsets
`define OFS_IMPL_CFG   12'h000
`define OFS_WAIT_EN    12'h004
`define OFS_STATUS     12'h008
`define OFS_TB_LO      12'h00c
`define OFS_TB_HI      12'h010
`define OFS_DEC        12'h014
`define OFS_DEC_CTRL   12'h018
// Fields of impl_config_register
`define CFG_DOZE       0
`define CFG_NAP        1
`define CFG_SLEEP      2
`define CFG_SEL_TBCLK  3
`define CFG_WIDTH      4
// Fields of decrementer control
`define DEC_IEN        0
`define DEC_FLAG       1
// Reset values
`define RST_IMPL_CFG   4'h0
`define RST_WAIT_EN    1'b0
// Flush countdown loaded once the bus is idle; buffer flush lasts this count plus one cycle before halting
`define FLUSH_CYCLES   4'h4
// AXI responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// ### rtl/pwr_seq_pkg.sv
// Types for the core power-state sequencer
// Assumes the map header sits beside it
package pwr_seq_pkg;
	typedef enum logic [2:0] {
		st_active,
		st_drain,
		st_flush,
		st_halted,
		st_stopped
	} pstate_type;

	typedef struct packed {
		pstate_type  st;
		logic [3:0]  cnt;
		logic        halt_s1, halt_s2, stop_s1, stop_s2;
		logic        tbdis_s1, tbdis_s2, tbclk_s1, tbclk_s2, tbclk_s3;
		logic        bus_idle_s1, bus_idle_s2;
		logic [3:0]  cfg;
		logic        wait_en;
		logic [63:0] tb;
		logic [31:0] dec;
		logic        dec_ien, dec_flag;
		logic        halted, stopped, doze, nap, sleep, wakeup, tbint;
		logic        exec_en, bus_req_en, flush_req, clk_en_fu, clk_en_idle;
		logic        awready, wready, bvalid, arready, rvalid;
		logic [31:0] rdata;
		logic [1:0]  bresp, rresp;
		logic        aw_held, w_held;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} state_type;
endpackage

// ### rtl/core_power_state_control.sv
// Power-state sequencer of a processor core, with its AXI4-Lite registers
// Assumes request pins are asynchronous and the bus runs on aclk
//
// What this block does
// - Reset enters active state, all clocks on
// - Active state gates idle unit clocks automatically
// - Halted suspends execution, bus, most clocks
// - Halted status output high while halted
// - Drain bus and flush buffers before halting
// - Power-down gates all but time base
// - Stop only via halted; then assert stopped
// - Timer disable input freezes the time base
// - Frozen time base cannot wake the core
// - Time base may run from external clock
// - Mode indicators follow bits only when enabled
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "pwr_seq_map.svh"

module core_power_state_control (
	input  wire logic        aclk,        // Core clock, 100 MHz
	input  wire logic        aresetn,     // Synchronous reset, active low
	input  wire logic        halt_req,    // Halt request pin
	input  wire logic        stop_req,    // Stop request pin
	input  wire logic        tb_disable,  // Time base freeze pin
	input  wire logic        tb_ext_clk,  // External time base tick pin
	input  wire logic        bus_idle,    // No bus transaction outstanding
	input  wire logic        unit_busy,   // Execution units have work
	input  wire logic [11:0] s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte enables
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [11:0] s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	output logic             halted,      // Core is halted
	output logic             stopped,     // Core is powered down
	output logic             doze,        // Doze mode indicator
	output logic             nap,         // Nap mode indicator
	output logic             sleep,       // Sleep mode indicator
	output logic             wakeup,      // Wake request to clock control
	output logic             tb_int,      // Timer interrupt status
	output logic             exec_en,     // Instruction execution allowed
	output logic             bus_req_en,  // New bus requests allowed
	output logic             flush_req,   // Flush store and push buffers
	output logic             clk_en_fu,   // Functional unit clock enable
	output logic             clk_en_idle  // Clock enable of idle units
);

	pwr_seq_pkg::state_type s_q, s_d;

	// Next state of everything in the block
	always_comb begin
		logic        tb_tick;
		logic        tb_run;
		logic        aw_now, w_now, ar_now;
		logic [11:0] wa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [31:0] rd;
		tb_tick = 1'b0;
		tb_run  = 1'b0;
		aw_now  = 1'b0;
		w_now   = 1'b0;
		ar_now  = 1'b0;
		wa      = 12'h000;
		wd      = 32'h0000_0000;
		ws      = 4'h0;
		rd      = 32'h0000_0000;
		s_d     = s_q;

		// Two-flop synchronisers for pins
		s_d.halt_s1     = halt_req;
		s_d.halt_s2     = s_q.halt_s1;
		s_d.stop_s1     = stop_req;
		s_d.stop_s2     = s_q.stop_s1;
		s_d.tbdis_s1    = tb_disable;
		s_d.tbdis_s2    = s_q.tbdis_s1;
		s_d.tbclk_s1    = tb_ext_clk;
		s_d.tbclk_s2    = s_q.tbclk_s1;
		s_d.tbclk_s3    = s_q.tbclk_s2;
		s_d.bus_idle_s1 = bus_idle;
		s_d.bus_idle_s2 = s_q.bus_idle_s1;

		// Power state machine
		unique case (s_q.st)
			pwr_seq_pkg::st_active: begin
				if (s_q.halt_s2) begin
					s_d.st = pwr_seq_pkg::st_drain;
				end
			end
			pwr_seq_pkg::st_drain: begin
				if (!s_q.halt_s2) begin
					s_d.st = pwr_seq_pkg::st_active;
				end else if (s_q.bus_idle_s2) begin
					s_d.st  = pwr_seq_pkg::st_flush;
					s_d.cnt = `FLUSH_CYCLES;
				end
			end
			pwr_seq_pkg::st_flush: begin
				if (s_q.cnt == 4'h0) begin
					s_d.st = pwr_seq_pkg::st_halted;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			pwr_seq_pkg::st_halted: begin
				if (s_q.stop_s2) begin
					s_d.st = pwr_seq_pkg::st_stopped;
				end else if (!s_q.halt_s2) begin
					s_d.st = pwr_seq_pkg::st_active;
				end
			end
			pwr_seq_pkg::st_stopped: begin
				if (!s_q.stop_s2) begin
					s_d.st = s_q.halt_s2 ? pwr_seq_pkg::st_halted
					                     : pwr_seq_pkg::st_active;
				end
			end
		endcase

		s_d.halted     = (s_d.st == pwr_seq_pkg::st_halted);
		s_d.stopped    = (s_d.st == pwr_seq_pkg::st_stopped);
		s_d.exec_en    = (s_d.st == pwr_seq_pkg::st_active);
		s_d.bus_req_en = (s_d.st == pwr_seq_pkg::st_active);
		s_d.flush_req  = (s_d.st == pwr_seq_pkg::st_flush);
		s_d.clk_en_fu  = !(s_d.halted || s_d.stopped);
		s_d.clk_en_idle = s_d.clk_en_fu && unit_busy;

		tb_tick = s_q.cfg[`CFG_SEL_TBCLK] ? (s_q.tbclk_s2 && !s_q.tbclk_s3)
		                                  : 1'b1;
		tb_run = tb_tick && !s_q.tbdis_s2;
		if (tb_run) begin
			s_d.tb = s_q.tb + 64'h1;
			if (s_q.dec != 32'h0000_0000) begin
				s_d.dec = s_q.dec - 32'h1;
				if (s_q.dec == 32'h0000_0001) begin
					s_d.dec_flag = 1'b1;
				end
			end
		end

		// AXI write channels, taken in either order
		aw_now = s_axi_awvalid && s_q.awready;
		w_now  = s_axi_wvalid && s_q.wready;
		if (aw_now) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
			s_d.awready = 1'b0;
		end
		if (w_now) begin
			s_d.w_held = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
			s_d.wready = 1'b0;
		end
		wa = aw_now ? s_axi_awaddr : s_q.awaddr;
		wd = w_now ? s_axi_wdata : s_q.wdata;
		ws = w_now ? s_axi_wstrb : s_q.wstrb;
		if ((aw_now || s_q.aw_held) && (w_now || s_q.w_held) &&
		    !s_q.bvalid) begin
			s_d.aw_held = 1'b0;
			s_d.w_held  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = `RESP_OKAY;
			unique case (wa & 12'hffc)
				`OFS_IMPL_CFG: begin
					if (ws[0]) begin
						s_d.cfg = wd[`CFG_WIDTH-1:0];
					end
				end
				`OFS_WAIT_EN: begin
					if (ws[0]) begin
						s_d.wait_en = wd[0];
					end
				end
				`OFS_DEC: begin
					if (ws == 4'hf) begin
						s_d.dec = wd;
					end
				end
				`OFS_DEC_CTRL: begin
					if (ws[0]) begin
						s_d.dec_ien = wd[`DEC_IEN];
						// Write one clears, a new expiry wins
						if (wd[`DEC_FLAG] && !(tb_run &&
						    s_q.dec == 32'h0000_0001)) begin
							s_d.dec_flag = 1'b0;
						end
					end
				end
				`OFS_STATUS, `OFS_TB_LO, `OFS_TB_HI: begin
					s_d.bresp = `RESP_OKAY;
				end
				default: begin
					s_d.bresp = `RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid  = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end

		// AXI read channel
		ar_now = s_axi_arvalid && s_q.arready;
		unique case (s_axi_araddr & 12'hffc)
			`OFS_IMPL_CFG: rd = {28'h0, s_q.cfg};
			`OFS_WAIT_EN:  rd = {31'h0, s_q.wait_en};
			`OFS_STATUS:   rd = {27'h0, s_q.st == pwr_seq_pkg::st_active,
			                     s_q.tbdis_s2, s_q.stop_s2,
			                     s_q.stopped, s_q.halted};
			`OFS_TB_LO:    rd = s_q.tb[31:0];
			`OFS_TB_HI:    rd = s_q.tb[63:32];
			`OFS_DEC:      rd = s_q.dec;
			`OFS_DEC_CTRL: rd = {30'h0, s_q.dec_flag, s_q.dec_ien};
			default:       rd = 32'h0000_0000;
		endcase
		if (ar_now) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rdata   = rd;
			s_d.rresp   = ((s_axi_araddr & 12'hffc) > `OFS_DEC_CTRL)
			              ? `RESP_SLVERR : `RESP_OKAY;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end

		s_d.doze  = s_d.wait_en && s_d.cfg[`CFG_DOZE];
		s_d.nap   = s_d.wait_en && s_d.cfg[`CFG_NAP];
		s_d.sleep = s_d.wait_en && s_d.cfg[`CFG_SLEEP];
		s_d.tbint = s_d.dec_flag && s_d.dec_ien;
		s_d.wakeup = s_d.tbint && !s_q.tbdis_s2 &&
		             (s_q.cfg[`CFG_SEL_TBCLK] ||
		              s_q.st != pwr_seq_pkg::st_stopped) &&
		             (s_q.halted || s_q.stopped);
	end

	// Register the whole state; reset enters active
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q             <= '0;
			s_q.st          <= pwr_seq_pkg::st_active;
			s_q.cfg         <= `RST_IMPL_CFG;
			s_q.wait_en     <= `RST_WAIT_EN;
			s_q.exec_en     <= 1'b1;
			s_q.bus_req_en  <= 1'b1;
			s_q.clk_en_fu   <= 1'b1;
			s_q.clk_en_idle <= 1'b1;
			s_q.awready     <= 1'b1;
			s_q.wready      <= 1'b1;
			s_q.arready     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready  = s_q.wready;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign halted        = s_q.halted;
	assign stopped       = s_q.stopped;
	assign doze          = s_q.doze;
	assign nap           = s_q.nap;
	assign sleep         = s_q.sleep;
	assign wakeup        = s_q.wakeup;
	assign tb_int        = s_q.tbint;
	assign exec_en       = s_q.exec_en;
	assign bus_req_en    = s_q.bus_req_en;
	assign flush_req     = s_q.flush_req;
	assign clk_en_fu     = s_q.clk_en_fu;
	assign clk_en_idle   = s_q.clk_en_idle;

endmodule // core_power_state_control

// ### test/core_power_state_control_properties.sv
// Checker of the power-state outputs of the core sequencer
// Assumes binding into the top module, ports seen by name
`timescale 1ns/100ps

module core_power_state_control_checker (
	input wire logic aclk,       // Clock
	input wire logic aresetn,    // Reset, low
	input wire logic halt_req,   // Halt pin
	input wire logic stop_req,   // Stop pin
	input wire logic unit_busy,  // Units busy
	input wire logic halted,     // Halted
	input wire logic stopped,    // Stopped
	input wire logic exec_en,    // Execute
	input wire logic bus_req_en, // Bus use
	input wire logic flush_req,  // Flush
	input wire logic clk_en_fu,  // Unit clock
	input wire logic clk_en_idle // Idle clock
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Reset release and clock gating
	property p_rst;
		$rose(aresetn) |-> !halted && !stopped && exec_en && clk_en_fu;
	endproperty
	a_rst: assert property (p_rst) else $error("not active at reset");
	property p_idle;
		$past(aresetn) && clk_en_fu && $past(clk_en_fu)
			|-> clk_en_idle == $past(unit_busy);
	endproperty
	a_idle: assert property (p_idle) else $error("idle gate wrong");
	property p_halt;
		halted |-> !exec_en && !bus_req_en && !clk_en_fu;
	endproperty
	a_halt: assert property (p_halt) else $error("halted not quiet");
	// Leaving halted needs the request gone
	property p_hold;
		$fell(halted) && !stopped |-> !$past(halt_req);
	endproperty
	a_hold: assert property (p_hold) else $error("halted dropped");
	property p_flush;
		$rose(halted) && !$past(stopped) |-> $past(flush_req);
	endproperty
	a_flush: assert property (p_flush) else $error("no flush");
	property p_stop;
		stopped |-> !clk_en_fu && !exec_en && !halted;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped not quiet");
	property p_via;
		$rose(stopped) |-> $past(halted);
	endproperty
	a_via: assert property (p_via) else $error("stop skipped halt");
	property p_exit;
		(!halt_req && !stop_req) [*8] |-> ##3 (!halted && !stopped);
	endproperty
	a_exit: assert property (p_exit) else $error("no return");
endmodule // core_power_state_control_checker

bind core_power_state_control core_power_state_control_checker i_chk (
	.aclk, .aresetn, .halt_req, .stop_req, .unit_busy, .halted, .stopped,
	.exec_en, .bus_req_en, .flush_req, .clk_en_fu, .clk_en_idle
);

// ### test/sys_ctrl_model.sv
// Model of the integrated logic: power requests and bus drain
// Assumes the bench asks for states; aclk is never stopped here
`timescale 1ns/100ps

module sys_ctrl_model (
	input  wire logic aclk,      // Clock
	input  wire logic want_halt, // Halt wanted
	input  wire logic want_stop, // Stop wanted
	input  wire logic slow,      // Long drain
	input  wire logic halted,    // Core halted
	output logic      halt_req,  // Halt pin
	output logic      stop_req,  // Stop pin
	output logic      bus_idle   // Bus drained
);
	logic [3:0] busy_q; // Traffic cycles left
	initial {halt_req, stop_req, busy_q} = '0;
	always @(posedge aclk) begin
		halt_req <= want_halt;
		stop_req <= want_stop & (halted | stop_req);
		busy_q <= (want_halt & !halt_req & slow) ? 4'hc
			: busy_q - 4'(busy_q != 4'h0);
	end
	assign bus_idle = (busy_q == 4'h0);
endmodule // sys_ctrl_model

// ### test/tb_top.sv
// Self-checking bench of the core power-state sequencer
// Assumes the bound checker and the system model beside the core
`timescale 1ns/100ps
`include "pwr_seq_map.svh"

module tb_top;
	logic aclk, aresetn, tb_disable, tb_ext_clk, unit_busy, halted, stopped;
	logic want_halt, want_stop, slow, halt_req, stop_req, bus_idle, doze;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, t0;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, nap;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, sleep;
	logic s_axi_rvalid, s_axi_rready, wakeup, tb_int, exec_en, bus_req_en;
	logic flush_req, clk_en_fu, clk_en_idle;
	int n_mismatch, compares, i;
	// Rows: {cfg mode bits, wait enable, expected sleep nap doze}
	logic [6:0] rows [6] = '{7'h5d, 7'h50, 7'h2a, 7'h70, 7'h7f, 7'h08};

	core_power_state_control i_core_power_state_control (.aclk, .aresetn,
		.halt_req, .stop_req, .tb_disable, .tb_ext_clk, .bus_idle, .unit_busy,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .halted, .stopped, .doze, .nap, .sleep, .wakeup,
		.tb_int, .exec_en, .bus_req_en, .flush_req, .clk_en_fu, .clk_en_idle);
	sys_ctrl_model i_sys_ctrl_model (.aclk, .want_halt, .want_stop, .slow,
		.halted, .halt_req, .stop_req, .bus_idle);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Busy pattern for the idle gating
	always @(posedge aclk) unit_busy <= ~unit_busy;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One AXI4-Lite transfer; handshakes sampled at rising edges
	task automatic axi(input bit wr, input logic [11:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while ((wr ? s_axi_bvalid & s_axi_bready
			: s_axi_rvalid & s_axi_rready) !== 1'b1 && t < 99);
		rs = wr ? s_axi_bresp : s_axi_rresp;
		rd = s_axi_rdata;
		{s_axi_bready, s_axi_rready} <= 2'b00;
		if (t >= 99) chk(32'h0, 32'h1);
	endtask
	task automatic until_st(input logic [1:0] hs);
		for (int t = 0; t < 300 && {halted, stopped} !== hs; t++)
			@(negedge aclk);
		chk(32'({halted, stopped}), 32'(hs));
	endtask
	task automatic final_report;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		final_report;
	end
	initial begin
		{aresetn, tb_disable, tb_ext_clk, unit_busy, want_halt, want_stop} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, slow, n_mismatch, compares} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Mode indicators against the table
		for (i = 0; i < 6; i++) begin
			axi(1, `OFS_IMPL_CFG, 32'(rows[i][6:4]));
			axi(1, `OFS_WAIT_EN, 32'(rows[i][3]));
			@(negedge aclk);
			chk(32'({sleep, nap, doze}), 32'(rows[i][2:0]));
		end
		axi(1, 12'h020, 32'h1);
		chk(32'(rs), 32'(`RESP_SLVERR));
		axi(0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		chk(32'(rs), 32'(`RESP_SLVERR));
		// Halt behind a slow bus drain
		slow <= 1'b1;
		want_halt <= 1'b1;
		// no halt while the bus still busy
		repeat (12) @(negedge aclk);
		chk(32'(halted), 32'h0);
		until_st(2'b10);
		chk(32'({exec_en, bus_req_en, clk_en_fu}), 32'h0);
		axi(0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h01);
		// Frozen time base cannot wake, live one can
		tb_disable <= 1'b1;
		axi(1, `OFS_DEC, 32'h3);
		axi(1, `OFS_DEC_CTRL, 32'h1);
		axi(0, `OFS_TB_LO, 32'h0);
		t0 = rd;
		axi(0, `OFS_TB_LO, 32'h0);
		chk(rd, t0);
		chk(32'(wakeup), 32'h0);
		tb_disable <= 1'b0;
		repeat (20) @(negedge aclk);
		chk(32'({wakeup, tb_int}), 32'h3);
		// Pending timer cannot wake once frozen
		@(posedge aclk);
		tb_disable <= 1'b1;
		repeat (4) @(negedge aclk);
		chk(32'({wakeup, tb_int}), 32'h1);
		@(posedge aclk);
		tb_disable <= 1'b0;
		// Power-down with the external time base tick
		@(posedge aclk);
		want_stop <= 1'b1;
		until_st(2'b01);
		chk(32'(clk_en_fu), 32'h0);
		axi(1, `OFS_IMPL_CFG, 32'h8);
		axi(0, `OFS_TB_LO, 32'h0);
		t0 = rd;
		repeat (10) begin
			repeat (4) @(posedge aclk);
			tb_ext_clk <= ~tb_ext_clk;
		end
		axi(0, `OFS_TB_LO, 32'h0);
		chk(rd, t0 + 32'h5);
		// Requests removed, then prompt halt and reset in mid-run
		@(posedge aclk);
		{want_stop, want_halt, slow} <= 3'b000;
		until_st(2'b00);
		chk(32'({exec_en, clk_en_fu}), 32'h3);
		@(posedge aclk);
		want_halt <= 1'b1;
		until_st(2'b10);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(32'({halted, stopped, exec_en, clk_en_fu}), 32'h3);
		axi(0, `OFS_IMPL_CFG, 32'h0);
		chk(rd, 32'(`RST_IMPL_CFG));
		final_report;
	end
endmodule // tb_top
